/* File: include/ltc_pkg.sv */
// constants, register map and types of the LIN transceiver control block
`default_nettype none
package ltc_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int US_DIV = 1_000_000;
    // dominant run that a wake-up must exceed, rounded up to whole cycles
    localparam int WAKE_DOM_US = 70;
    localparam int WAKE_CYCLES = (WAKE_DOM_US * CLK_HZ + US_DIV - 1) / US_DIV;
    // transmit dominant timeout, longest time rounded down
    localparam int TXDOM_US = 300;
    localparam int TXDOM_CYCLES_DEF = (TXDOM_US * CLK_HZ) / US_DIV;
    localparam int CNT_W = 16;

    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_CLR = 8'h0c;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_EN = 8'h10;

    localparam logic [2:0] SEL_CTRL = 3'h0;
    localparam logic [2:0] SEL_STATUS = 3'h1;
    localparam logic [2:0] SEL_ISTAT = 3'h2;
    localparam logic [2:0] SEL_ICLR = 3'h3;
    localparam logic [2:0] SEL_IEN = 3'h4;
    localparam logic [2:0] SEL_NONE = 3'h7;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        MODE_DISABLE = 2'h0,
        MODE_TXRX = 2'h1,
        MODE_SLEEP = 2'h2,
        MODE_RSV = 2'h3
    } ltc_mode_t;

    typedef enum logic [1:0] {
        RATE_20K = 2'h0,
        RATE_10K = 2'h1,
        RATE_FAST = 2'h2,
        RATE_RSV = 2'h3
    } ltc_rate_t;

    typedef enum logic [1:0] {
        WK_IDLE = 2'h0,
        WK_DOM = 2'h1,
        WK_QUAL = 2'h2
    } ltc_wk_t;

    typedef struct packed {
        logic wake_en;
        ltc_rate_t rate;
        ltc_mode_t mode;
    } ltc_ctrl_t;
    localparam int CTRL_W = 5;
    localparam ltc_ctrl_t CTRL_RST = '{wake_en: 1'b0, rate: RATE_20K, mode: MODE_DISABLE};

    typedef struct packed {
        logic ot;
        logic uv;
        logic dom_to;
        logic bus_level;
        logic active;
    } ltc_status_t;

    // sticky event bits, same layout in stat, clear and enable registers
    localparam int IRQ_W = 2;
    localparam int IRQ_DOMTO_BIT = 0;
    localparam int IRQ_WAKE_BIT = 1;

    // synchronised pins: transmit input, bus level, undervoltage, overtemperature
    localparam int SY_TX = 0;
    localparam int SY_BUS = 1;
    localparam int SY_UV = 2;
    localparam int SY_OT = 3;
    localparam int SY_W = 4;
    localparam logic [SY_W-1:0] SYNC_RST = 4'h3;
endpackage
`default_nettype wire

/* File: src/ltc_top.sv */
// LIN transceiver control: modes, rate, timeouts, shutdowns, wake-up, AXI4-Lite registers
// Behaviour
// - bus driver and receiver act only in Normal device mode.
// - three rates, 20 kbps, 10 kbps and fast, chosen by register write.
// - chosen rate sets the transmit edge profile output.
// - supply undervoltage keeps the bus recessive whatever transmit input does.
// - overtemperature disables driver and receiver, recovering by itself.
// - transmit input low drives dominant, high releases the bus.
// - undriven transmit input counts as high, never dominant.
// - transmit low beyond timeout forces recessive and sets a readable flag.
// - receive output high for recessive bus, low for dominant.
// - three operating modes, transmit/receive, sleep and disable.
// - transmit/receive command taken only while transmit input is high.
// - sleep entered by command, driver off, bus watched for wake-up.
// - sleep switches high-value pull-up on and low-value one off.
// - qualifying bus activity ends sleep and reports a wake-up.
// - wake-up needs falling edge, dominant over 70 us, rising edge.
// - wake-up raises interrupt, and also restarts regulator when it is off.
`default_nettype none
module ltc_top
    import ltc_pkg::*;
#(
    parameter int TXDOM_CYCLES = TXDOM_CYCLES_DEF,
    parameter int WAKE_MIN = WAKE_CYCLES
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic NORMAL_MODE,
    input wire logic LP_VDD_OFF,
    input wire logic BUS_LINE_ONE_TX_IN,
    output logic BUS_LINE_ONE_RX_OUT,
    input wire logic BUS_LINE_ONE_IN,
    output logic BUS_LINE_ONE_OUT,
    output logic BUS_LINE_ONE_OE,
    input wire logic LIN_SUPPLY_UV,
    input wire logic LIN_OVERTEMP,
    output logic [1:0] SLEW_SEL,
    output logic PULLUP_LOW_EN,
    output logic PULLUP_HIGH_EN,
    output logic VDD_RESTART,
    output logic IRQ
);
    if (TXDOM_CYCLES < 2 || TXDOM_CYCLES >= (1 << CNT_W)) begin : g_chk_to
        $error("TXDOM_CYCLES out of range");
    end
    if (WAKE_MIN < 1 || WAKE_MIN >= (1 << CNT_W) - 1) begin : g_chk_wk
        $error("WAKE_MIN out of range");
    end

    localparam logic [CNT_W-1:0] TO_LAST = CNT_W'(TXDOM_CYCLES - 1);
    localparam logic [CNT_W-1:0] WK_LAST = CNT_W'(WAKE_MIN);

    function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
        case (a)
            ADDR_CTRL: reg_sel = SEL_CTRL;
            ADDR_STATUS: reg_sel = SEL_STATUS;
            ADDR_IRQ_STAT: reg_sel = SEL_ISTAT;
            ADDR_IRQ_CLR: reg_sel = SEL_ICLR;
            ADDR_IRQ_EN: reg_sel = SEL_IEN;
            default: reg_sel = SEL_NONE;
        endcase
    endfunction

    // pin synchronisers; first stage feeds only the second
    logic [SY_W-1:0] sy1, sy2, sy3, filt;
    logic [SY_W-1:0] sy_raw;
    logic [SY_W-1:0] sy_agree;
    assign sy_raw = {LIN_OVERTEMP, LIN_SUPPLY_UV, BUS_LINE_ONE_IN, BUS_LINE_ONE_TX_IN};
    assign sy_agree = ~(sy2 ^ sy3);

    // tx resets to high so nothing dominant leaves before the pin settles
    always_ff @(posedge CLK) begin
        if (RST) begin
            sy1 <= SYNC_RST;
            sy2 <= SYNC_RST;
            sy3 <= SYNC_RST;
            filt <= SYNC_RST;
        end else begin
            sy1 <= sy_raw;
            sy2 <= sy1;
            sy3 <= sy2;
            filt <= (sy3 & sy_agree) | (filt & ~sy_agree);
        end
    end

    logic tx_f, bus_f, uv_f, ot_f;
    assign tx_f = filt[SY_TX];
    assign bus_f = filt[SY_BUS];
    assign uv_f = filt[SY_UV];
    assign ot_f = filt[SY_OT];

    // AXI4-Lite write channel
    logic aw_full, w_full, aw_rdy, w_rdy, bvalid;
    logic [1:0] bresp;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic w_lane0;
    logic aw_hs, w_hs, wr_do;
    logic next_aw_full, next_w_full;
    logic [2:0] wsel;
    assign aw_hs = S_AXI_AWVALID && aw_rdy;
    assign w_hs = S_AXI_WVALID && w_rdy;
    assign wr_do = aw_full && w_full && !bvalid;
    assign next_aw_full = (aw_full || aw_hs) && !wr_do;
    assign next_w_full = (w_full || w_hs) && !wr_do;
    assign wsel = reg_sel(aw_addr);

    always_ff @(posedge CLK) begin
        if (RST) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_rdy <= 1'b0;
            w_rdy <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_lane0 <= 1'b0;
        end else begin
            aw_full <= next_aw_full;
            w_full <= next_w_full;
            aw_rdy <= !next_aw_full;
            w_rdy <= !next_w_full;
            if (aw_hs) begin
                aw_addr <= S_AXI_AWADDR;
            end
            if (w_hs) begin
                w_data <= S_AXI_WDATA;
                w_lane0 <= S_AXI_WSTRB[0];
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (wr_do) begin
            bvalid <= 1'b1;
            bresp <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (S_AXI_BREADY) begin
            bvalid <= 1'b0;
        end
    end

    logic ctrl_wr, clr_wr, en_wr;
    assign ctrl_wr = wr_do && wsel == SEL_CTRL && w_lane0;
    assign clr_wr = wr_do && wsel == SEL_ICLR && w_lane0;
    assign en_wr = wr_do && wsel == SEL_IEN && w_lane0;

    // control register: mode, rate, wake enable
    ltc_ctrl_t ctrl, wr_ctrl;
    logic wake_pulse;
    logic wr_ok;
    assign wr_ctrl = ltc_ctrl_t'(w_data[CTRL_W-1:0]);
    // reserved codes and a txrx request with the input low drop the whole write
    assign wr_ok = wr_ctrl.mode != MODE_RSV && wr_ctrl.rate != RATE_RSV
        && !(wr_ctrl.mode == MODE_TXRX && !tx_f);

    always_ff @(posedge CLK) begin
        if (RST) begin
            ctrl <= CTRL_RST;
        end else if (wake_pulse) begin
            ctrl.mode <= MODE_DISABLE;
        end else if (ctrl_wr && wr_ok) begin
            ctrl <= wr_ctrl;
        end
    end

    // transmit path
    logic lin_on;
    logic [CNT_W-1:0] dom_cnt;
    logic dom_to, dom_hit;
    assign lin_on = NORMAL_MODE && ctrl.mode == MODE_TXRX && !ot_f;
    assign dom_hit = lin_on && !tx_f && !dom_to && dom_cnt == TO_LAST;

    always_ff @(posedge CLK) begin
        if (RST) begin
            dom_cnt <= '0;
            dom_to <= 1'b0;
        end else if (!lin_on || tx_f) begin
            dom_cnt <= '0;
            dom_to <= 1'b0;
        end else if (dom_cnt == TO_LAST) begin
            dom_to <= 1'b1;
        end else begin
            dom_cnt <= dom_cnt + 1'b1;
        end
    end

    logic drv, rx_out;
    always_ff @(posedge CLK) begin
        if (RST) begin
            drv <= 1'b0;
            rx_out <= 1'b1;
        end else begin
            drv <= lin_on && !uv_f && !dom_to && !tx_f;
            rx_out <= !lin_on || bus_f;
        end
    end

    // wake-up detector, armed only in sleep with detection enabled
    ltc_wk_t wk_st;
    logic [CNT_W-1:0] wk_cnt;
    logic bus_prev, wk_on;
    assign wk_on = ctrl.mode == MODE_SLEEP && ctrl.wake_en;
    assign wake_pulse = wk_on && wk_st == WK_QUAL && bus_f;

    always_ff @(posedge CLK) begin
        if (RST) begin
            bus_prev <= 1'b1;
        end else begin
            bus_prev <= bus_f;
        end
    end

    // a bus already dominant when sleep starts has no falling edge and is skipped
    always_ff @(posedge CLK) begin
        if (RST) begin
            wk_st <= WK_IDLE;
            wk_cnt <= '0;
        end else if (!wk_on) begin
            wk_st <= WK_IDLE;
            wk_cnt <= '0;
        end else begin
            case (wk_st)
                WK_IDLE: begin
                    if (bus_prev && !bus_f) begin
                        wk_st <= WK_DOM;
                        wk_cnt <= CNT_W'(1);
                    end
                end
                WK_DOM: begin
                    if (bus_f) begin
                        wk_st <= WK_IDLE;
                    end else if (wk_cnt == WK_LAST) begin
                        wk_st <= WK_QUAL;
                    end else begin
                        wk_cnt <= wk_cnt + 1'b1;
                    end
                end
                WK_QUAL: begin
                    if (bus_f) begin
                        wk_st <= WK_IDLE;
                    end
                end
                default: wk_st <= WK_IDLE;
            endcase
        end
    end

    // interrupt status, set wins over a clear in the same cycle
    logic [IRQ_W-1:0] irq_stat, irq_en, irq_set;
    always_comb begin
        irq_set = '0;
        irq_set[IRQ_DOMTO_BIT] = dom_hit;
        irq_set[IRQ_WAKE_BIT] = wake_pulse;
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            irq_stat <= '0;
        end else if (clr_wr) begin
            irq_stat <= irq_set | (irq_stat & ~w_data[IRQ_W-1:0]);
        end else begin
            irq_stat <= irq_set | irq_stat;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            irq_en <= '0;
        end else if (en_wr) begin
            irq_en <= w_data[IRQ_W-1:0];
        end
    end

    // pin-facing outputs, all registered
    logic irq_q, restart, pu_low, pu_high;
    logic [1:0] slew;
    always_ff @(posedge CLK) begin
        if (RST) begin
            irq_q <= 1'b0;
            restart <= 1'b0;
            slew <= RATE_20K;
            pu_low <= 1'b1;
            pu_high <= 1'b0;
        end else begin
            irq_q <= |(irq_stat & irq_en);
            restart <= wake_pulse && LP_VDD_OFF;
            slew <= ctrl.rate;
            pu_low <= ctrl.mode != MODE_SLEEP;
            pu_high <= ctrl.mode == MODE_SLEEP;
        end
    end

    // AXI4-Lite read channel, one cycle from address to data
    logic ar_rdy, rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic ar_hs;
    ltc_status_t status;
    assign ar_hs = S_AXI_ARVALID && ar_rdy;
    assign status = '{ot: ot_f, uv: uv_f, dom_to: dom_to, bus_level: bus_f, active: lin_on};

    always_ff @(posedge CLK) begin
        if (RST) begin
            ar_rdy <= 1'b0;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else if (ar_hs) begin
            ar_rdy <= 1'b0;
            rvalid <= 1'b1;
            rresp <= RESP_OKAY;
            case (reg_sel(S_AXI_ARADDR))
                SEL_CTRL: rdata <= 32'(ctrl);
                SEL_STATUS: rdata <= 32'(status);
                SEL_ISTAT: rdata <= 32'(irq_stat);
                SEL_IEN: rdata <= 32'(irq_en);
                SEL_ICLR: rdata <= '0;
                default: begin
                    rdata <= '0;
                    rresp <= RESP_SLVERR;
                end
            endcase
        end else if (rvalid && S_AXI_RREADY) begin
            rvalid <= 1'b0;
            ar_rdy <= 1'b1;
        end else begin
            ar_rdy <= !rvalid;
        end
    end

    assign S_AXI_AWREADY = aw_rdy;
    assign S_AXI_WREADY = w_rdy;
    assign S_AXI_BVALID = bvalid;
    assign S_AXI_BRESP = bresp;
    assign S_AXI_ARREADY = ar_rdy;
    assign S_AXI_RVALID = rvalid;
    assign S_AXI_RDATA = rdata;
    assign S_AXI_RRESP = rresp;
    assign BUS_LINE_ONE_RX_OUT = rx_out;
    assign BUS_LINE_ONE_OUT = 1'b0;
    assign BUS_LINE_ONE_OE = drv;
    assign SLEW_SEL = slew;
    assign PULLUP_LOW_EN = pu_low;
    assign PULLUP_HIGH_EN = pu_high;
    assign VDD_RESTART = restart;
    assign IRQ = irq_q;

    // helper: consecutive dominant cycles seen by the receiver
    logic [CNT_W-1:0] dom_run;
    always_ff @(posedge CLK) begin
        if (RST || bus_f) begin
            dom_run <= '0;
        end else if (dom_run != '1) begin
            dom_run <= dom_run + 1'b1;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    inactive_bus_a: assert property (!NORMAL_MODE |=> !BUS_LINE_ONE_OE && BUS_LINE_ONE_RX_OUT)
        else $error("bus active outside normal mode");
    rate_legal_a: assert property (SLEW_SEL != RATE_RSV)
        else $error("reserved rate reached the slew select");
    uv_recessive_a: assert property (uv_f |=> !BUS_LINE_ONE_OE)
        else $error("bus driven during undervoltage");
    ot_off_a: assert property (ot_f |=> !BUS_LINE_ONE_OE && BUS_LINE_ONE_RX_OUT)
        else $error("driver or receiver on in overtemperature");
    tx_follow_a: assert property (
        lin_on && !uv_f && !dom_to |=> BUS_LINE_ONE_OE == !$past(tx_f))
        else $error("bus does not follow transmit input");
    timeout_force_a: assert property (
        dom_hit |=> dom_to && irq_stat[IRQ_DOMTO_BIT] ##1 !BUS_LINE_ONE_OE)
        else $error("dominant timeout did not release the bus");
    rx_mirror_a: assert property (lin_on |=> BUS_LINE_ONE_RX_OUT == $past(bus_f))
        else $error("receive output does not mirror the bus");
    txrx_guard_a: assert property ($rose(ctrl.mode == MODE_TXRX) |-> $past(tx_f))
        else $error("transmit mode taken with input low");
    sleep_pullup_a: assert property (
        ctrl.mode == MODE_SLEEP |=> PULLUP_HIGH_EN && !PULLUP_LOW_EN)
        else $error("sleep pull-ups wrong");
    wake_leave_a: assert property (
        wake_pulse |=> ctrl.mode == MODE_DISABLE && irq_stat[IRQ_WAKE_BIT])
        else $error("wake-up did not end sleep");
    wake_len_a: assert property (wake_pulse |-> dom_run > WK_LAST)
        else $error("wake-up on a short dominant pulse");
    wake_restart_a: assert property (wake_pulse && LP_VDD_OFF |=> VDD_RESTART)
        else $error("regulator restart missing");

    wake_seen_c: cover property (wake_pulse);
    timeout_seen_c: cover property (dom_hit);
    txrx_refused_c: cover property (ctrl_wr && wr_ctrl.mode == MODE_TXRX && !tx_f);
    clr_set_c: cover property (clr_wr && |irq_set);
endmodule
`default_nettype wire

/* File: test/ltc_bus_node.sv */
// far side of the lin line: pull-up plus a second node on the wire
`default_nettype none
module ltc_bus_node (
    input wire logic dut_oe,
    input wire logic node_pull,
    output logic bus_level
);
    timeunit 1ns;
    timeprecision 1ns;
    // wired-and: the pull-up wins only while neither node pulls the line low
    assign bus_level = !(dut_oe || node_pull);
endmodule
`default_nettype wire

/* File: test/test_lin_transceiver_control.sv */
// self-checking bench for the lin transceiver control block
`default_nettype none
module test_lin_transceiver_control
    import ltc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TDOM = 20;
    localparam int WMIN = 10;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] awaddr = '0;
    logic [ADDR_W-1:0] araddr = '0;
    logic [31:0] wdata = '0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic tx = 1'b1;
    logic normal = 1'b1;
    logic lpoff = 1'b0;
    logic uv = 1'b0;
    logic ot = 1'b0;
    logic node_pull = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic rx, bus, bus_out, oe, pu_lo, pu_hi, restart, irq;
    logic [1:0] bresp, rresp, slew, resp;
    logic [31:0] rdata, data;
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int restart_cnt = 0;

    ltc_top #(.TXDOM_CYCLES(TDOM), .WAKE_MIN(WMIN)) u_dut (
        .CLK(clk), .RST(rst),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(1'b1), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(1'b1),
        .NORMAL_MODE(normal), .LP_VDD_OFF(lpoff), .BUS_LINE_ONE_TX_IN(tx), .BUS_LINE_ONE_RX_OUT(rx),
        .BUS_LINE_ONE_IN(bus), .BUS_LINE_ONE_OUT(bus_out), .BUS_LINE_ONE_OE(oe),
        .LIN_SUPPLY_UV(uv), .LIN_OVERTEMP(ot), .SLEW_SEL(slew),
        .PULLUP_LOW_EN(pu_lo), .PULLUP_HIGH_EN(pu_hi), .VDD_RESTART(restart), .IRQ(irq)
    );

    ltc_bus_node u_node (.dut_oe(oe), .node_pull(node_pull), .bus_level(bus));

    always #50 clk = ~clk;

    // the restart pulse lasts one cycle, so count it as it passes
    always @(posedge clk) begin
        if (restart === 1'b1) restart_cnt++;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc >= 20000) begin
            err_count++;
            final_report();
        end
    end

    task automatic final_report;
        $display("checks %0d errors %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask

    // bready stays high, so the edge that shows bvalid is the response
    // no local limit: a hung slave is caught by the cycle timeout
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        resp = bresp;
    endtask

    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        data = rdata;
        resp = rresp;
    endtask

    task automatic pulse(input int n);
        node_pull <= 1'b1;
        wt(n);
        node_pull <= 1'b0;
        wt(8);
    endtask

    task automatic t_reset;
        chk("rx idle", rx, 1);
        chk("drive idle", oe, 0);
        chk("low pull-up", pu_lo, 1);
        chk("high pull-up", pu_hi, 0);
        chk("slew reset", slew, RATE_20K);
        rd(ADDR_CTRL);
        chk("ctrl reset", data, 0);
        rd(8'h14);
        chk("unmapped read", resp, RESP_SLVERR);
        wr(8'h14, 1);
        chk("unmapped write", resp, RESP_SLVERR);
    endtask

    task automatic t_rate;
        for (int r = 2; r >= 0; r--) begin
            wr(ADDR_CTRL, r << 2);
            wt(2);
            chk("slew select", slew, r);
            rd(ADDR_CTRL);
            chk("rate readback", data, r << 2);
        end
        wr(ADDR_CTRL, 32'h0c);
        rd(ADDR_CTRL);
        chk("reserved rate", data, 0);
    endtask

    task automatic t_mode;
        tx <= 1'b0;
        wt(8);
        wr(ADDR_CTRL, MODE_TXRX);
        chk("refused write resp", resp, RESP_OKAY);
        rd(ADDR_CTRL);
        chk("txrx refused", data, MODE_DISABLE);
        tx <= 1'b1;
        wt(8);
        wr(ADDR_CTRL, MODE_TXRX);
        rd(ADDR_STATUS);
        chk("active", data[0], 1);
    endtask

    // own echo needs tx sync, drive edge and bus sync: about ten cycles
    task automatic t_drive;
        tx <= 1'b0;
        wt(12);
        chk("dominant drive", oe, 1);
        chk("drive level", bus_out, 0);
        chk("rx dominant", rx, 0);
        tx <= 1'b1;
        wt(12);
        chk("recessive drive", oe, 0);
        chk("rx recessive", rx, 1);
        node_pull <= 1'b1;
        wt(8);
        chk("rx other node", rx, 0);
        normal <= 1'b0;
        wt(3);
        chk("rx outside normal", rx, 1);
        tx <= 1'b0;
        wt(8);
        chk("no drive outside normal", oe, 0);
        tx <= 1'b1;
        node_pull <= 1'b0;
        wr(ADDR_CTRL, MODE_DISABLE);
        normal <= 1'b1;
        tx <= 1'b0;
        wt(8);
        chk("no drive when disabled", oe, 0);
        tx <= 1'b1;
        wt(8);
        wr(ADDR_CTRL, MODE_TXRX);
    endtask

    task automatic t_fault;
        uv <= 1'b1;
        tx <= 1'b0;
        wt(8);
        chk("undervoltage recessive", oe, 0);
        uv <= 1'b0;
        wt(8);
        chk("undervoltage gone", oe, 1);
        tx <= 1'b1;
        ot <= 1'b1;
        wt(8);
        tx <= 1'b0;
        node_pull <= 1'b1;
        wt(8);
        chk("overtemp driver", oe, 0);
        chk("overtemp receiver", rx, 1);
        ot <= 1'b0;
        node_pull <= 1'b0;
        wt(8);
        chk("overtemp recovery", oe, 1);
        tx <= 1'b1;
        wt(8);
    endtask

    task automatic t_timeout;
        wr(ADDR_IRQ_EN, 1);
        tx <= 1'b0;
        wt(8);
        chk("before timeout", oe, 1);
        wt(TDOM + 4);
        chk("timeout release", oe, 0);
        rd(ADDR_STATUS);
        chk("timeout live", data[2], 1);
        rd(ADDR_IRQ_STAT);
        chk("timeout event", data, 1);
        chk("irq raised", irq, 1);
        tx <= 1'b1;
        wt(8);
        tx <= 1'b0;
        wt(8);
        chk("timeout restart", oe, 1);
        tx <= 1'b1;
        wr(ADDR_IRQ_EN, 0);
        wt(2);
        chk("irq masked", irq, 0);
        wr(ADDR_IRQ_CLR, 1);
        rd(ADDR_IRQ_STAT);
        chk("event cleared", data, 0);
    endtask

    task automatic t_wake;
        wr(ADDR_IRQ_EN, 2);
        lpoff <= 1'b1;
        wr(ADDR_CTRL, 32'h02);
        pulse(WMIN + 6);
        rd(ADDR_CTRL);
        chk("wake disabled", data, 32'h02);
        wr(ADDR_CTRL, 32'h12);
        wt(2);
        chk("sleep high pull-up", pu_hi, 1);
        chk("sleep low pull-up", pu_lo, 0);
        tx <= 1'b0;
        wt(8);
        chk("sleep no drive", oe, 0);
        tx <= 1'b1;
        pulse(WMIN - 4);
        rd(ADDR_CTRL);
        chk("short pulse", data, 32'h12);
        pulse(WMIN + 6);
        rd(ADDR_CTRL);
        chk("wake exit", data, 32'h10);
        chk("restart pulse", restart_cnt, 1);
        chk("wake irq", irq, 1);
        chk("pull-up restored", pu_lo, 1);
        rd(ADDR_IRQ_STAT);
        chk("wake event", data, 2);
        lpoff <= 1'b0;
        wr(ADDR_CTRL, 32'h12);
        pulse(WMIN + 6);
        rd(ADDR_CTRL);
        chk("wake regulator on", data, 32'h10);
        chk("no restart when on", restart_cnt, 1);
    endtask

    initial begin
        wt(16);
        rst <= 1'b0;
        wt(4);
        t_reset();
        t_rate();
        t_mode();
        t_drive();
        t_fault();
        t_timeout();
        t_wake();
        final_report();
    end
endmodule
`default_nettype wire
